// *** core/rf_port_cfg.svh ***
// Register offsets, field positions and reset values of the RF front-end control
// Contract
// - Bit 12 picks port arrangement: 1 single
// - Port arrangement bit resets to 0 (dual)
// - Single port: shared pin pair is bidirectional
// - Single RX: receive switch on, shared amp off
// - Single TX: receive switch off, shared amp on
// - Dual: shared amp off, separate amp transmits
// - Bit 14 enables bias output, else tri-state
// - Bit 13 inverts, only enabled dual port
// - Single enabled: high TX, low RX
// - Dual enabled: high TX, low RX, inverted optional
// - Enabled: low in idle, doze, hibernate
`ifndef RF_PORT_CFG_SVH
`define RF_PORT_CFG_SVH

`define RF_REG_ADDR_W        6
`define RF_REG_DATA_W        16
`define RF_FRONT_END_CTRL    6'h07
`define RF_FRONT_END_RESET   16'h0000
`define RF_BIT_PORT_SELECT   12
`define RF_BIT_BIAS_INVERT   13
`define RF_BIT_BIAS_ENABLE   14

`endif

// *** core/rf_port_pkg.sv ***
// Types shared by the RF front-end control modules
package rf_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_RX        = 3'b001,
        ST_TX        = 3'b010,
        ST_DOZE      = 3'b011,
        ST_HIBERNATE = 3'b100
    } radio_state_e;

endpackage

// *** core/rf_ctrl_if.sv ***
// Configuration and drive signals between register file and path decoder
`timescale 1ns/1ns
`default_nettype none
interface rf_ctrl_if;
    import rf_port_pkg::*;

    logic         single_port;
    logic         bias_enable;
    logic         bias_invert;
    radio_state_e state;
    logic         rx_switch_en;
    logic         shared_amp_en;
    logic         separate_amp_en;
    logic         bias_level;
    logic         bias_oe;

    modport cfg (output single_port, bias_enable, bias_invert, state,
                 input  rx_switch_en, shared_amp_en, separate_amp_en, bias_level, bias_oe);
    modport dec (input  single_port, bias_enable, bias_invert, state,
                 output rx_switch_en, shared_amp_en, separate_amp_en, bias_level, bias_oe);
endinterface
`default_nettype wire

// *** core/rf_path_decode.sv ***
// Path enables and bias/switch level from port arrangement and radio state
`timescale 1ns/1ns
`default_nettype none
module rf_path_decode (
    // Configuration in, drives out
    rf_ctrl_if.dec ctl
);
    import rf_port_pkg::*;

    always_comb
    begin
        ctl.rx_switch_en    = 1'b0;
        ctl.shared_amp_en   = 1'b0;
        ctl.separate_amp_en = 1'b0;
        ctl.bias_level      = 1'b0;
        ctl.bias_oe         = ctl.bias_enable;
        unique case (ctl.state)
            ST_RX:
            begin
                ctl.rx_switch_en = 1'b1;
                // Single port ignores invert; dual uses it
                ctl.bias_level   = ctl.single_port ? 1'b0 : ctl.bias_invert;
            end
            ST_TX:
            begin
                ctl.shared_amp_en   = ctl.single_port;
                ctl.separate_amp_en = ~ctl.single_port;
                ctl.bias_level      = ctl.single_port ? 1'b1 : ~ctl.bias_invert;
            end
            ST_IDLE, ST_DOZE, ST_HIBERNATE:
            begin
                ctl.bias_level = 1'b0;
            end
            default:
            begin
                // Unused state code: all paths off, output low if driven
                ctl.bias_level = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// *** core/rf_port_mode_and_bias_control.sv ***
// RF front-end control: control register, path enables, bias/switch output
`timescale 1ns/1ns
`default_nettype none
`include "rf_port_cfg.svh"
module rf_port_mode_and_bias_control (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // Register port
    input  wire logic [`RF_REG_ADDR_W-1:0]    reg_addr,
    input  wire logic [`RF_REG_DATA_W-1:0]    reg_wdata,
    input  wire logic                         reg_write,
    output logic      [`RF_REG_DATA_W-1:0]    reg_rdata,
    // Radio state from modem sequencer
    input  wire rf_port_pkg::radio_state_e    radio_state,
    // Internal RF path controls
    output logic                              port_arrangement_select,
    output logic                              rf_shared_bidir,
    output logic                              rx_switch_en,
    output logic                              shared_path_amp_en,
    output logic                              separate_path_amp_en,
    // Bias/switch control pin
    output logic                              bias_switch_out,
    output logic                              bias_switch_out_oe
);
    import rf_port_pkg::*;

    logic [`RF_REG_DATA_W-1:0] ctrl_q;
    logic [`RF_REG_DATA_W-1:0] ctrl_d;
    logic [`RF_REG_DATA_W-1:0] rdata_q;
    logic [`RF_REG_DATA_W-1:0] rdata_d;
    logic                      hit;

    rf_ctrl_if ctl ();

    // Register write and read-back
    assign hit = (reg_addr == `RF_FRONT_END_CTRL);

    always_comb
    begin
        ctrl_d = ctrl_q;
        if (reg_write && hit)
        begin
            ctrl_d = reg_wdata;
        end
        rdata_d = hit ? ctrl_d : '0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_q  <= `RF_FRONT_END_RESET;
            rdata_q <= '0;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Field extraction into the decoder
    assign ctl.single_port = ctrl_q[`RF_BIT_PORT_SELECT];
    assign ctl.bias_enable = ctrl_q[`RF_BIT_BIAS_ENABLE];
    assign ctl.bias_invert = ctrl_q[`RF_BIT_BIAS_INVERT];
    // State goes straight through so outputs track it without delay
    assign ctl.state       = radio_state;

    rf_path_decode u_decode (
        .ctl (ctl.dec)
    );

    assign port_arrangement_select = ctrl_q[`RF_BIT_PORT_SELECT];
    assign rf_shared_bidir         = ctrl_q[`RF_BIT_PORT_SELECT];
    assign rx_switch_en            = ctl.rx_switch_en;
    assign shared_path_amp_en      = ctl.shared_amp_en;
    assign separate_path_amp_en    = ctl.separate_amp_en;
    // Level forced low when not driven, so the pin value is defined
    assign bias_switch_out         = ctl.bias_oe & ctl.bias_level;
    assign bias_switch_out_oe      = ctl.bias_oe;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_ctrl_write;
        reg_write && hit;
    endsequence

    sequence s_enabled_single;
        ctrl_q[`RF_BIT_BIAS_ENABLE] && ctrl_q[`RF_BIT_PORT_SELECT];
    endsequence

    sequence s_enabled_dual;
        ctrl_q[`RF_BIT_BIAS_ENABLE] && !ctrl_q[`RF_BIT_PORT_SELECT];
    endsequence

    sequence s_no_write;
        !(reg_write && hit);
    endsequence

    property p_mode_write;
        s_ctrl_write |=> (port_arrangement_select == $past(reg_wdata[`RF_BIT_PORT_SELECT]))
            && (reg_rdata[`RF_BIT_PORT_SELECT] == $past(reg_wdata[`RF_BIT_PORT_SELECT]));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("port arrangement bit did not follow write");

    property p_reset_defaults;
        @(posedge clk) disable iff (1'b0)
        reset |=> !port_arrangement_select && !bias_switch_out_oe && (ctrl_q == `RF_FRONT_END_RESET);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("control register not at defaults after reset");

    property p_single_bidir;
        s_ctrl_write |=> rf_shared_bidir == $past(reg_wdata[`RF_BIT_PORT_SELECT]);
    endproperty
    a_single_bidir: assert property (p_single_bidir)
        else $error("shared pins direction mismatch");

    property p_single_rx;
        port_arrangement_select && (radio_state == ST_RX) |-> rx_switch_en && !shared_path_amp_en;
    endproperty
    a_single_rx: assert property (p_single_rx)
        else $error("single port receive path wrong");

    property p_single_tx;
        port_arrangement_select && (radio_state == ST_TX)
            |-> !rx_switch_en && shared_path_amp_en && !separate_path_amp_en;
    endproperty
    a_single_tx: assert property (p_single_tx)
        else $error("single port transmit path wrong");

    property p_dual_paths;
        !port_arrangement_select |-> !shared_path_amp_en
            && (separate_path_amp_en == (radio_state == ST_TX))
            && (rx_switch_en == (radio_state == ST_RX));
    endproperty
    a_dual_paths: assert property (p_dual_paths)
        else $error("dual port path enables wrong");

    property p_tristate;
        !ctrl_q[`RF_BIT_BIAS_ENABLE] |-> !bias_switch_out_oe;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("bias output driven while disabled");

    property p_invert_scope;
        s_enabled_single |-> bias_switch_out == (radio_state == ST_TX);
    endproperty
    a_invert_scope: assert property (p_invert_scope)
        else $error("single port bias level wrong");

    property p_dual_level;
        s_enabled_dual ##0 ((radio_state == ST_TX) || (radio_state == ST_RX))
            |-> bias_switch_out == ((radio_state == ST_TX) ^ ctrl_q[`RF_BIT_BIAS_INVERT]);
    endproperty
    a_dual_level: assert property (p_dual_level)
        else $error("dual port bias level wrong");

    property p_low_states;
        ctrl_q[`RF_BIT_BIAS_ENABLE]
            && (radio_state inside {ST_IDLE, ST_DOZE, ST_HIBERNATE})
            |-> bias_switch_out_oe && !bias_switch_out;
    endproperty
    a_low_states: assert property (p_low_states)
        else $error("bias output not driven low in quiet state");

    property p_same_cycle;
        $changed(radio_state) && (radio_state == ST_TX)
            |-> (shared_path_amp_en || separate_path_amp_en) && !rx_switch_en;
    endproperty
    a_same_cycle: assert property (p_same_cycle)
        else $error("path enables lag radio state");

    property p_enable_write;
        s_ctrl_write |=> bias_switch_out_oe == $past(reg_wdata[`RF_BIT_BIAS_ENABLE]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("bias enable did not follow write");

    property p_invert_write;
        s_ctrl_write |=> reg_rdata[`RF_BIT_BIAS_INVERT] == $past(reg_wdata[`RF_BIT_BIAS_INVERT]);
    endproperty
    a_invert_write: assert property (p_invert_write)
        else $error("invert bit did not follow write");

    property p_ctrl_hold;
        s_no_write |=> $stable(port_arrangement_select) && $stable(bias_switch_out_oe);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control bits changed without a write");

    property p_reset_rdata;
        @(posedge clk) disable iff (1'b0)
        reset |=> (reg_rdata == '0);
    endproperty
    a_reset_rdata: assert property (p_reset_rdata)
        else $error("read data not cleared by reset");

    property p_disabled_low;
        !bias_switch_out_oe |-> !bias_switch_out;
    endproperty
    a_disabled_low: assert property (p_disabled_low)
        else $error("bias level not held low while released");

    property p_leave_tx;
        $changed(radio_state) && (radio_state != ST_TX)
            |-> !shared_path_amp_en && !separate_path_amp_en;
    endproperty
    a_leave_tx: assert property (p_leave_tx)
        else $error("amplifier still on after leaving transmit");

    property p_enter_rx;
        $changed(radio_state) && (radio_state == ST_RX)
            |-> rx_switch_en && !shared_path_amp_en && !separate_path_amp_en;
    endproperty
    a_enter_rx: assert property (p_enter_rx)
        else $error("receive path lags radio state");

endmodule
`default_nettype wire

// *** testbench/rf_far_side.sv ***
// Far-side model of the bias/switch pin: balun centre tap or antenna switch
`timescale 1ns/1ns
`default_nettype none
module rf_far_side (
    // Pin drive from the device
    input  wire logic bias_switch_out,
    input  wire logic bias_switch_out_oe,
    // Level seen by the external parts
    output logic      pin_level
);
    logic last_q = 1'b0;
    // No pull on the pin: released shows the opposite of the last level
    always_comb pin_level = bias_switch_out_oe ? bias_switch_out : ~last_q;
    always @(bias_switch_out or bias_switch_out_oe)
        if (bias_switch_out_oe)
            last_q = bias_switch_out;
endmodule
`default_nettype wire

// *** testbench/rf_port_mode_and_bias_control_test.sv ***
// Self-checking bench of the RF front-end control block
`timescale 1ns/1ns
`default_nettype none
`include "rf_port_cfg.svh"
module rf_port_mode_and_bias_control_test;
    import rf_port_pkg::*;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic [5:0]   reg_addr = 6'h00;
    logic [15:0]  reg_wdata = 16'h0000;
    logic         reg_write = 1'b0;
    radio_state_e radio_state = ST_IDLE;
    logic [15:0]  reg_rdata;
    logic         port_sel, bidir, rx_sw, amp1, amp2, bias, bias_oe, pin_level;
    int           fail_count = 0;
    int           checked = 0;

    always #2 clk = ~clk;

    rf_port_mode_and_bias_control i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata), .radio_state(radio_state),
        .port_arrangement_select(port_sel), .rf_shared_bidir(bidir), .rx_switch_en(rx_sw),
        .shared_path_amp_en(amp1), .separate_path_amp_en(amp2), .bias_switch_out(bias),
        .bias_switch_out_oe(bias_oe));
    rf_far_side i_far (.bias_switch_out(bias), .bias_switch_out_oe(bias_oe), .pin_level(pin_level));

    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1;
        cmp_word("reg_rdata", exp, reg_rdata);
    endtask

    // Every radio state plus one unused code, outputs checked in the same cycle
    task automatic sweep(input logic [15:0] cfg);
        logic sgl, en, inv, tx, rx, lvl;
        sgl = cfg[`RF_BIT_PORT_SELECT];
        en = cfg[`RF_BIT_BIAS_ENABLE];
        inv = cfg[`RF_BIT_BIAS_INVERT];
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            radio_state <= radio_state_e'(i);
            #1;
            tx = (i == 2);
            rx = (i == 1);
            lvl = en & (sgl ? tx : (tx ? ~inv : (rx & inv)));
            cmp_bit("port_sel", sgl, port_sel);
            cmp_bit("bidir", sgl, bidir);
            cmp_bit("rx_sw", rx, rx_sw);
            cmp_bit("amp1", sgl & tx, amp1);
            cmp_bit("amp2", ~sgl & tx, amp2);
            cmp_bit("bias_oe", en, bias_oe);
            cmp_bit("bias", lvl, bias);
            if (en)
                cmp_bit("pin_level", lvl, pin_level);
        end
    endtask

    task automatic test_reset;
        rd(`RF_FRONT_END_CTRL, 16'h0000);
        sweep(16'h0000);
        $display("test_reset done");
    endtask

    task automatic test_single;
        wr(`RF_FRONT_END_CTRL, 16'h5000);
        rd(`RF_FRONT_END_CTRL, 16'h5000);
        sweep(16'h5000);
        wr(`RF_FRONT_END_CTRL, 16'h7000);
        sweep(16'h7000);
        $display("test_single done");
    endtask

    task automatic test_dual;
        wr(`RF_FRONT_END_CTRL, 16'h4000);
        sweep(16'h4000);
        wr(`RF_FRONT_END_CTRL, 16'h6000);
        sweep(16'h6000);
        $display("test_dual done");
    endtask

    task automatic test_disabled;
        wr(`RF_FRONT_END_CTRL, 16'h3abc);
        sweep(16'h3abc);
        wr(6'h08, 16'hffff);
        rd(6'h08, 16'h0000);
        rd(`RF_FRONT_END_CTRL, 16'h3abc);
        $display("test_disabled done");
    endtask

    task automatic test_rerun_reset;
        wr(`RF_FRONT_END_CTRL, 16'h5000);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        rd(`RF_FRONT_END_CTRL, 16'h0000);
        sweep(16'h0000);
        $display("test_rerun_reset done");
    endtask

    task automatic end_sim;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        test_reset();
        test_single();
        test_dual();
        test_disabled();
        test_rerun_reset();
        end_sim();
    end
endmodule
`default_nettype wire
